// ### design/rcic_pkg.sv
// Purpose: shared constants for the resampling integrator-comb stage
// Assumes: 50 MHz master clock, byte-wide register addresses
// Notes: offsets are the register indices as printed, used as-is on the port
package rcic_pkg;
    // register map
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned RDATA_W = 16;
    localparam logic [7:0] ADDR_DEC = 8'h90;
    localparam logic [7:0] ADDR_INT = 8'h91;
    localparam logic [7:0] ADDR_SCALE = 8'h92;
    localparam logic [7:0] ADDR_STAT = 8'h93;
    localparam logic [7:0] ADDR_CTRL = 8'h94;
    // field widths and positions
    localparam int unsigned M_W = 12;
    localparam int unsigned L_W = 9;
    localparam int unsigned SCALE_W = 12;
    localparam int unsigned S_W = 5;
    localparam int unsigned EXP_W = 3;
    localparam int unsigned IN_W = 16;
    localparam int unsigned FINE_W = 3;
    localparam int unsigned LOUD_LSB = 0;
    localparam int unsigned QUIET_LSB = 5;
    localparam int unsigned STEP_BIT = 10;
    localparam int unsigned INV_BIT = 11;
    localparam int unsigned COARSE_LSB = 3;
    localparam int unsigned STAT_OVF_BIT = 0;
    localparam int unsigned STAT_LVL_LSB = 4;
    localparam int unsigned CTRL_DIV_BIT = 0;
    localparam logic [EXP_W-1:0] EXP_MAX = 3'h7;
    // reset values
    localparam logic [M_W-1:0] DEC_RST = 12'h000;
    localparam logic [L_W-1:0] INT_RST = 9'h000;
    localparam logic [SCALE_W-1:0] SCALE_RST = 12'h000;
    localparam logic [0:0] CTRL_RST = 1'h0;
    // datapath sizing: gain M*M/L is at most 2^24
    localparam int unsigned ACC_W = 40;
    localparam int unsigned OUT_W_DEF = 20;
    localparam int unsigned FIFO_DEPTH_DEF = 8;
    localparam int unsigned IN_SLACK = 6;
    // input rate limits
    localparam int unsigned CLK_KHZ = 50000;
    localparam int unsigned SINGLE_KHZ = 80000;
    localparam int unsigned DIVERS_KHZ = 40000;
    localparam int unsigned SINGLE_GAP_RAW = (CLK_KHZ + SINGLE_KHZ - 1) / SINGLE_KHZ;
    localparam int unsigned DIVERS_GAP_RAW = (CLK_KHZ + DIVERS_KHZ - 1) / DIVERS_KHZ;
    localparam int unsigned SINGLE_GAP = (SINGLE_GAP_RAW < 1) ? 1 : SINGLE_GAP_RAW;
    localparam int unsigned DIVERS_GAP = (DIVERS_GAP_RAW < 1) ? 1 : DIVERS_GAP_RAW;
    localparam logic [1:0] SINGLE_HOLD = 2'(SINGLE_GAP - 1);
    localparam logic [1:0] DIVERS_HOLD = 2'(DIVERS_GAP - 1);
endpackage

// ### design/rcic_acc.sv
// Purpose: wrapping accumulator used for both integrators
// Assumes: two's complement wrap is harmless since the comb undoes it
// Notes: sum_d shows the sum including the current addend
`timescale 1ns/1ps
module rcic_acc
    import rcic_pkg::*;
#(
    parameter int unsigned W = ACC_W
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic en,
    input wire logic signed [W-1:0] add,
    output logic signed [W-1:0] sum_q,
    output logic signed [W-1:0] sum_d
);
    logic signed [W-1:0] acc_q;
    logic signed [W-1:0] acc_d;

    // clear wins so a rate change starts from a clean state
    always_comb
    begin
        sum_d = acc_q + add;
        acc_d = acc_q;
        if (clr)
            acc_d = '0;
        else if (en)
            acc_d = sum_d;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            acc_q <= '0;
        else
            acc_q <= acc_d;
    end

    assign sum_q = acc_q;
endmodule // rcic_acc

// ### design/rcic_fifo.sv
// Purpose: output FIFO between the resampler and the next decimator
// Assumes: DEPTH is a power of two
// Notes: show-ahead; head word comes straight from the storage flops
`timescale 1ns/1ps
module rcic_fifo
    import rcic_pkg::*;
#(
    parameter int unsigned W = OUT_W_DEF,
    parameter int unsigned DEPTH = FIFO_DEPTH_DEF,
    localparam int unsigned AW = $clog2(DEPTH)
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [AW:0] level
);
    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] wr_d;
    logic [AW-1:0] rd_q;
    logic [AW-1:0] rd_d;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic push;
    logic pop;

    // handshakes straight from the count
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign level = cnt_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and storage next state
    always_comb
    begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push)
        begin
            mem_d[wr_q] = in_data;
            wr_d = wr_q + 1'b1;
        end
        if (pop)
            rd_d = rd_q + 1'b1;
        if (push && !pop)
            cnt_d = cnt_q + 1'b1;
        else if (pop && !push)
            cnt_d = cnt_q - 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
        mem_q <= mem_d;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_fifo_bound: assert property (cnt_q <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
    a_fifo_count: assert property (push && !pop |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("fifo count missed a push");
endmodule // rcic_fifo

// ### design/rcic_top.sv
// Purpose: resampling second-order integrator-comb stage with input scaling
// Assumes: wideband samples come from pins and are synchronised here
// Notes: registers on a plain strobe port; results leave through a FIFO
// Function
// - interpolation L from 1 to 512, decimation M from 1 to 4096
// - zero-stuff by L, then second-order integrator-comb filtering
// - input samples accepted at up to one per 50 MHz clock in single-channel mode
// - output rate equals input rate times L divided by M for L up to M; never more than one output per input
// - L and M both one bypasses filtering, rate unchanged
// - 5-bit attenuation 0 to 31, one power of two per step
// - attenuation applied also while filtering is bypassed
// - scale register holds strong scale bits 4-0, weak scale bits 9-5
// - input shifted right by (exponent+scale) mod 8, inverted form 7-exponent
// - decimation held as 12-bit M minus one
// - interpolation held as 9-bit L minus one
// - 80 MHz single-channel input, 40 MHz in diversity mode; taken at one per 50 MHz clock, one per two clocks in diversity
// - scale bit 10 selects 6 dB or 12 dB exponent steps
// - scale bit 11 inverts the external exponent
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module rcic_top
    import rcic_pkg::*;
#(
    parameter int unsigned OUT_W = OUT_W_DEF,
    parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF,
    localparam int unsigned LVL_W = $clog2(FIFO_DEPTH) + 1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [RDATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [RDATA_W-1:0] reg_rdata,
    input wire logic [IN_W-1:0] wb_data,
    input wire logic [EXP_W-1:0] wb_exp,
    input wire logic wb_valid,
    output logic wb_ready,
    output logic [OUT_W-1:0] dec_data,
    output logic dec_valid,
    input wire logic dec_ready
);
    localparam logic [LVL_W-1:0] RDY_LVL = LVL_W'(FIFO_DEPTH - IN_SLACK);

    // configuration and status
    logic [M_W-1:0] dec_q, dec_d;
    logic [L_W-1:0] int_q, int_d;
    logic [SCALE_W-1:0] scale_q, scale_d;
    logic div_q, div_d;
    logic ovf_q, ovf_d;
    logic ovf_set;
    logic [RDATA_W-1:0] rdata_q, rdata_d;
    logic cfg_clr;
    // input synchroniser
    logic [IN_W-1:0] s1_data_q, s2_data_q;
    logic [EXP_W-1:0] s1_exp_q, s2_exp_q;
    logic s1_valid_q, s2_valid_q;
    // scaling stage
    logic [S_W-1:0] loud, quiet, s_sel;
    logic [EXP_W-1:0] e_inv;
    logic [EXP_W:0] e_eff;
    logic [S_W:0] t_sum;
    logic [FINE_W-1:0] fine;
    logic signed [IN_W-1:0] sh_in;
    logic [1:0] hold;
    logic [1:0] since_q, since_d;
    logic take;
    logic signed [ACC_W-1:0] x_q, x_d;
    logic xv_q, xv_d;
    // resampler stage
    logic bypass;
    logic [M_W:0] m_full;
    logic [L_W:0] l_full;
    logic [M_W:0] p_q, p_d;
    logic [M_W:0] p_sum;
    logic [M_W:0] rem;
    logic signed [ACC_W-1:0] i1_q;
    logic signed [ACC_W-1:0] i1_sum;
    logic signed [ACC_W-1:0] i2_q;
    logic signed [ACC_W-1:0] i2_sum;
    logic signed [ACC_W-1:0] i2_add;
    logic signed [ACC_W-1:0] tap;
    logic integ_en;
    logic fire_q, fire_d;
    logic byp_q, byp_d;
    logic signed [ACC_W-1:0] cand_q, cand_d;
    // comb and output stage
    logic signed [ACC_W-1:0] c1_q, c1_d;
    logic signed [ACC_W-1:0] c2_q, c2_d;
    logic signed [ACC_W-1:0] y_q, y_d;
    logic yv_q, yv_d;
    logic [S_W-1:0] coarse;
    logic signed [ACC_W-1:0] y_sh;
    logic fifo_in_ready;
    logic [LVL_W-1:0] fifo_level;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // register writes; a rate change flushes the filter state
    always_comb
    begin
        dec_d = dec_q;
        int_d = int_q;
        scale_d = scale_q;
        div_d = div_q;
        ovf_d = ovf_q;
        if (reg_wr)
        begin
            case (reg_addr)
                ADDR_DEC: dec_d = reg_wdata[M_W-1:0];
                ADDR_INT: int_d = reg_wdata[L_W-1:0];
                ADDR_SCALE: scale_d = reg_wdata[SCALE_W-1:0];
                ADDR_CTRL: div_d = reg_wdata[CTRL_DIV_BIT];
                ADDR_STAT: ovf_d = ovf_q && !reg_wdata[STAT_OVF_BIT];
                default: ovf_d = ovf_q;
            endcase
        end
        if (ovf_set)
            ovf_d = 1'b1; // a new overrun beats the clear
        rdata_d = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_DEC: rdata_d = RDATA_W'(dec_q);
                ADDR_INT: rdata_d = RDATA_W'(int_q);
                ADDR_SCALE: rdata_d = RDATA_W'(scale_q);
                ADDR_CTRL: rdata_d = RDATA_W'(div_q);
                ADDR_STAT: rdata_d = RDATA_W'({fifo_level, 3'h0, ovf_q});
                default: rdata_d = '0;
            endcase
        end
    end

    assign cfg_clr = reg_wr && (reg_addr == ADDR_DEC || reg_addr == ADDR_INT);
    assign reg_rdata = rdata_q;

    // exponent handling and fine shift ahead of the integrators
    always_comb
    begin
        loud = scale_q[LOUD_LSB +: S_W];
        quiet = scale_q[QUIET_LSB +: S_W];
        e_inv = scale_q[INV_BIT] ? (EXP_MAX - s2_exp_q) : s2_exp_q;
        e_eff = scale_q[STEP_BIT] ? {e_inv, 1'b0} : {1'b0, e_inv};
        s_sel = (e_eff == '0) ? quiet : loud;
        t_sum = {2'b00, e_eff} + {1'b0, s_sel};
        fine = t_sum[FINE_W-1:0];
        sh_in = $signed(s2_data_q) >>> fine;
        hold = div_q ? DIVERS_HOLD : SINGLE_HOLD;
        take = s2_valid_q && (since_q >= hold);
        since_d = since_q;
        if (take)
            since_d = '0;
        else if (since_q != 2'h3)
            since_d = since_q + 2'h1;
        x_d = {{(ACC_W-IN_W){sh_in[IN_W-1]}}, sh_in};
        xv_d = take;
    end

    // zero-stuffed integrators: the first integrator sees the sample once,
    // the second adds it on each of the L stuffed ticks
    assign bypass = (dec_q == '0) && (int_q == '0);
    assign m_full = {1'b0, dec_q} + 13'h0001;
    assign l_full = {1'b0, int_q} + 10'h001;
    assign integ_en = xv_q && !bypass;
    assign i2_add = $signed({1'b0, l_full}) * i1_sum;

    rcic_acc #(
        .W(ACC_W)
    ) u_integ1 (
        .clk(clk),
        .rst_n(rst_n),
        .clr(cfg_clr),
        .en(integ_en),
        .add(x_q),
        .sum_q(i1_q),
        .sum_d(i1_sum)
    );

    rcic_acc #(
        .W(ACC_W)
    ) u_integ2 (
        .clk(clk),
        .rst_n(rst_n),
        .clr(cfg_clr),
        .en(integ_en),
        .add(i2_add),
        .sum_q(i2_q),
        .sum_d()
    );

    // output phase: an output lands on stuffed tick rem when rem <= L
    always_comb
    begin
        rem = m_full - p_q;
        tap = $signed({1'b0, rem}) * i1_sum;
        i2_sum = i2_q + tap;
        p_sum = p_q + {3'b000, l_full};
        p_d = p_q;
        if (cfg_clr)
            p_d = '0;
        else if (integ_en)
            p_d = (p_sum >= m_full) ? (p_sum - m_full) : p_sum;
        fire_d = xv_q && (bypass || rem <= {3'b000, l_full});
        byp_d = bypass;
        cand_d = bypass ? x_q : i2_sum;
    end

    // second-order comb at the output rate
    always_comb
    begin
        c1_d = c1_q;
        c2_d = c2_q;
        y_d = y_q;
        yv_d = fire_q && !cfg_clr;
        if (cfg_clr)
        begin
            c1_d = '0;
            c2_d = '0;
        end
        else if (fire_q && byp_q)
            y_d = cand_q;
        else if (fire_q)
        begin
            y_d = cand_q - (c1_q <<< 1) + c2_q;
            c1_d = cand_q;
            c2_d = c1_q;
        end
    end

    // coarse attenuation in whole bytes, applied even in bypass
    assign coarse = {loud[S_W-1:COARSE_LSB], 3'b000};
    assign y_sh = y_q >>> coarse;
    assign ovf_set = (s2_valid_q && !take) || (yv_q && !fifo_in_ready);
    // ready leaves room for samples already inside the pipeline
    assign wb_ready = (fifo_level <= RDY_LVL);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dec_q <= DEC_RST;
            int_q <= INT_RST;
            scale_q <= SCALE_RST;
            div_q <= CTRL_RST;
            ovf_q <= 1'b0;
            rdata_q <= '0;
            s1_valid_q <= 1'b0;
            s2_valid_q <= 1'b0;
            since_q <= 2'h3;
            xv_q <= 1'b0;
            p_q <= '0;
            fire_q <= 1'b0;
            byp_q <= 1'b0;
            c1_q <= '0;
            c2_q <= '0;
            yv_q <= 1'b0;
        end
        else
        begin
            dec_q <= dec_d;
            int_q <= int_d;
            scale_q <= scale_d;
            div_q <= div_d;
            ovf_q <= ovf_d;
            rdata_q <= rdata_d;
            s1_valid_q <= wb_valid;
            s2_valid_q <= s1_valid_q;
            since_q <= since_d;
            xv_q <= xv_d;
            p_q <= p_d;
            fire_q <= fire_d;
            byp_q <= byp_d;
            c1_q <= c1_d;
            c2_q <= c2_d;
            yv_q <= yv_d;
        end
        s1_data_q <= wb_data;
        s2_data_q <= s1_data_q;
        s1_exp_q <= wb_exp;
        s2_exp_q <= s1_exp_q;
        x_q <= x_d;
        cand_q <= cand_d;
        y_q <= y_d;
    end

    rcic_fifo #(
        .W(OUT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(yv_q),
        .in_ready(fifo_in_ready),
        .in_data(y_sh[OUT_W-1:0]),
        .out_valid(dec_valid),
        .out_ready(dec_ready),
        .out_data(dec_data),
        .level(fifo_level)
    );

    sequence s_byp_take;
        xv_q && bypass && !cfg_clr;
    endsequence

    sequence s_byp_out;
        ##1 fire_q ##1 yv_q;
    endsequence

    a_bypass_pass: assert property (s_byp_take |-> s_byp_out)
        else $error("bypassed sample did not pass through");
    a_fire_cause: assert property (fire_q |-> $past(xv_q))
        else $error("output without an input sample");
    a_phase_step: assert property (integ_en && !cfg_clr |=>
        p_q == $past((p_sum % {1'b0, m_full})))
        else $error("phase did not advance by L modulo M");
    a_fine_shift: assert property (!scale_q[STEP_BIT] |->
        fine == FINE_W'((scale_q[INV_BIT] ? (EXP_MAX - s2_exp_q) : s2_exp_q) + s_sel))
        else $error("fine shift not exponent plus scale mod 8");
    a_div_spacing: assert property (div_q && xv_d |=> !xv_d)
        else $error("diversity mode took samples back to back");
    a_dec_write: assert property (reg_wr && reg_addr == ADDR_DEC |=>
        dec_q == $past(reg_wdata[M_W-1:0]))
        else $error("decimation register not updated");
    a_int_write: assert property (reg_wr && reg_addr == ADDR_INT |=>
        int_q == $past(reg_wdata[L_W-1:0]))
        else $error("interpolation register not updated");
    a_ovf_sticky: assert property (ovf_set |=> ovf_q)
        else $error("overrun flag lost");
endmodule // rcic_top

// ### sim/rcic_adc_model.sv
// Purpose: behavioural gain-ranging converter feeding wideband samples
// Assumes: caller enters send just after a rising clock edge
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
module rcic_adc_model
    import rcic_pkg::*;
(
    input wire logic clk,
    input wire logic obey,
    input wire logic wb_ready,
    output logic [IN_W-1:0] wb_data,
    output logic [EXP_W-1:0] wb_exp,
    output logic wb_valid,
    output logic late
);
    initial
    begin
        wb_data = '0;
        wb_exp = '0;
        wb_valid = 1'b0;
        late = 1'b0;
    end

    // n samples spaced gap cycles; obey low lets a scenario overrun the buffer
    task automatic send(input logic [IN_W-1:0] d, input logic [EXP_W-1:0] e,
                        input int n, input int gap);
        int w;
        for (int k = 0; k < n; k++)
        begin
            if (obey && !wb_ready)
            begin
                wb_valid <= 1'b0;
                w = 0;
                while (!wb_ready && w < 200)
                begin
                    @(posedge clk);
                    w++;
                end
                // a ready that never returns is reported, not silently ignored
                if (w >= 200)
                    late <= 1'b1;
            end
            wb_data <= d;
            wb_exp <= e;
            wb_valid <= 1'b1;
            @(posedge clk);
            // one-cycle valid per sample, spacing set by gap
            if (gap > 1 || k == n - 1)
            begin
                wb_valid <= 1'b0;
                wb_data <= ~d;
                wb_exp <= ~e;
            end
            repeat (gap - 1) @(posedge clk);
        end
    endtask
endmodule // rcic_adc_model

// ### sim/tb.sv
// Purpose: self-checking bench for the resampling integrator-comb stage
// Assumes: registers reached over the plain strobe port, one clock
// Notes: output words captured into a queue on every pop
`timescale 1ns/1ps
module tb;
    import rcic_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [RDATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [RDATA_W-1:0] reg_rdata;
    logic [IN_W-1:0] wb_data;
    logic [EXP_W-1:0] wb_exp;
    logic wb_valid;
    logic wb_ready;
    logic [OUT_W_DEF-1:0] dec_data;
    logic dec_valid;
    logic dec_ready = 1'b1;
    logic obey = 1'b1;
    logic adc_late;
    int err_count = 0;
    int cmp_count = 0;
    logic [OUT_W_DEF-1:0] got_q[$];
    logic [RDATA_W-1:0] rd_v;
    logic [7:0] ra [3] = '{ADDR_DEC, ADDR_INT, ADDR_SCALE};
    logic [15:0] rm [3] = '{16'h0fff, 16'h01ff, 16'h0fff};

    // 50 MHz master clock
    always #10 clk = ~clk;

    rcic_top i_rcic_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .wb_data(wb_data), .wb_exp(wb_exp), .wb_valid(wb_valid), .wb_ready(wb_ready),
        .dec_data(dec_data), .dec_valid(dec_valid), .dec_ready(dec_ready));

    rcic_adc_model i_rcic_adc_model (.clk(clk), .obey(obey), .wb_ready(wb_ready),
        .wb_data(wb_data), .wb_exp(wb_exp), .wb_valid(wb_valid), .late(adc_late));

    // every pop is one output strobe
    always @(posedge clk)
    begin
        if (rst_n && dec_valid && dec_ready)
            got_q.push_back(dec_data);
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
        end
    endtask

    // extra edge at the end so back-to-back calls never double-drive the strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
        @(posedge clk);
    endtask

    task automatic wait_out(input int n);
        int w;
        w = 0;
        while (got_q.size() < n && w < 2000)
        begin
            @(posedge clk);
            w++;
        end
        if (w >= 2000)
        begin
            chk("output count", 20'(got_q.size()), 20'(n));
            print_verdict();
        end
    endtask

    task automatic setup(input int l, input int m, input logic [15:0] sc);
        wr(ADDR_DEC, 16'(m - 1));
        wr(ADDR_INT, 16'(l - 1));
        wr(ADDR_SCALE, sc);
        repeat (4) @(posedge clk);
        got_q.delete();
    endtask

    // bypass result: fine shift mod 8 on the input, coarse in whole bytes
    function automatic logic [19:0] exp_out(input logic [15:0] x, input logic [2:0] e,
                                            input logic [15:0] sc);
        logic [3:0] ef;
        logic [4:0] s;
        logic signed [19:0] v;
        ef = sc[INV_BIT] ? 4'(3'h7 - e) : 4'(e);
        if (sc[STEP_BIT])
            ef = ef << 1;
        s = (ef == 4'h0) ? sc[9:5] : sc[4:0];
        v = signed'({{4{x[15]}}, x});
        v = v >>> ((ef + s) % 8);
        v = v >>> (8 * sc[4:3]); // coarse always follows the strong field
        return v;
    endfunction

    task automatic one(input logic [2:0] e, input logic [15:0] sc);
        i_rcic_adc_model.send(16'h8a40, e, 1, 1);
        wait_out(1);
        chk("scaled sample", got_q.pop_front(), exp_out(16'h8a40, e, sc));
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("ready after reset", 20'(wb_ready), 20'h1);
        for (int i = 0; i < 3; i++)
        begin
            rd(ra[i]);
            chk("reg reset", 20'(rd_v), 20'h0);
            wr(ra[i], 16'hffff);
            rd(ra[i]);
            chk("reg width", 20'(rd_v), 20'(rm[i]));
        end
        #1 chk("rdata one cycle", 20'(reg_rdata), 20'h0);
        @(posedge clk);
        rd(8'h95);
        chk("unmapped read", 20'(rd_v), 20'h0);
        $display("test registers done");
        // bypass: every exponent under each invert and step setting
        setup(1, 1, 16'h0000);
        for (int s = 2; s < 10; s += 7)
        begin
            for (int c = 0; c < 4; c++)
            begin
                wr(ADDR_SCALE, {4'h0, 2'(c), 5'(s), 5'(s)});
                for (int e = 0; e < 8; e++)
                    one(3'(e), {4'h0, 2'(c), 5'(s), 5'(s)});
            end
        end
        // weak fine field for a zero exponent, strong otherwise; coarse from strong
        wr(ADDR_SCALE, 16'h0069);
        one(3'h0, 16'h0069);
        one(3'h1, 16'h0069);
        got_q.delete();
        i_rcic_adc_model.send(16'h0123, 3'h0, 8, 1);
        wait_out(8);
        repeat (20) @(posedge clk);
        chk("bypass count", 20'(got_q.size()), 20'h8);
        $display("test bypass done");
        // simplest ratios, smallest safe scale: steady output 16x>>4 and 8x>>3
        for (int t = 0; t < 2; t++)
        begin
            setup(t + 1, 4, t ? 16'h0063 : 16'h0084);
            i_rcic_adc_model.send(16'h0100, 3'h0, 40, 1);
            wait_out(10 * (t + 1));
            repeat (30) @(posedge clk);
            chk("resampled count", 20'(got_q.size()), 20'(10 * (t + 1)));
            chk("steady gain", got_q[$], 20'h00100);
        end
        $display("test resample done");
        // stall the far side, overrun the buffer, then drain it
        setup(1, 1, 16'h0000);
        dec_ready <= 1'b0;
        obey <= 1'b0;
        @(posedge clk);
        i_rcic_adc_model.send(16'h0042, 3'h0, 12, 1);
        repeat (10) @(posedge clk);
        chk("ready when full", 20'(wb_ready), 20'h0);
        rd(ADDR_STAT);
        chk("full status", 20'(rd_v), 20'h00081);
        wr(ADDR_STAT, 16'h0001);
        rd(ADDR_STAT);
        chk("overrun cleared", 20'(rd_v), 20'h00080);
        dec_ready <= 1'b1;
        obey <= 1'b1;
        wait_out(8);
        repeat (5) @(posedge clk);
        chk("drained count", 20'(got_q.size()), 20'h8);
        chk("drained valid", 20'(dec_valid), 20'h0);
        chk("drained word", got_q[0], 20'h00042);
        $display("test buffer done");
        // diversity mode: two-cycle spacing accepted, every cycle refused
        wr(ADDR_CTRL, 16'h0001);
        got_q.delete();
        i_rcic_adc_model.send(16'h0010, 3'h0, 4, 2);
        wait_out(4);
        rd(ADDR_STAT);
        chk("spaced samples", 20'(rd_v), 20'h0);
        i_rcic_adc_model.send(16'h0010, 3'h0, 4, 1);
        repeat (20) @(posedge clk);
        rd(ADDR_STAT);
        chk("fast samples", 20'(rd_v[0]), 20'h1);
        wr(ADDR_CTRL, 16'h0000);
        $display("test diversity done");
        chk("converter wait", 20'(adc_late), 20'h0);
        print_verdict();
    end
endmodule // tb
